// ==== design/recorder_pkg.sv ====
// Shared constants and types for the disturbance record controller.
package recorder_pkg;
    localparam int ANA_CH = 4;
    localparam int BIN_CH = 8;
    localparam int SMP_W = 16;
    localparam int LOCK_CH = ANA_CH + BIN_CH;
    localparam int SRC_MAN = LOCK_CH;
    localparam int SRC_PER = LOCK_CH + 1;
    localparam int SRC_N = LOCK_CH + 2;
    localparam int SRC_W = 4;
    localparam int MAX_REC = 100;
    localparam int SLOT_W = 7;
    localparam int TREND_MULT = 32;
    localparam int PCT_FULL = 100;
    localparam int LEN_W = 9;
    localparam int PCT_W = 7;
    localparam int SPC_W = 6;
    localparam int CNT_W = 16;
    localparam int LOCK_W = 20;
    localparam int CLK_NS = 25;
    localparam int MS_NS = 1000000;
    localparam int MS_CYC = MS_NS / CLK_NS;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [1:0] {ST_FILL = 2'b01, ST_POST = 2'b10} state_type;
    typedef enum logic [1:0] {
        KIND_HIST = 2'h0,
        KIND_POST = 2'h1,
        KIND_TREND = 2'h2
    } kind_type;

    typedef struct packed {
        logic [ANA_CH-1:0][SMP_W-1:0] analog;
        logic [BIN_CH-1:0] binary;
    } sample_type;

    typedef struct packed {
        logic [SLOT_W-1:0] slot;
        kind_type kind;
        sample_type data;
    } store_word_type;
endpackage : recorder_pkg

// ==== design/store_fifo.sv ====
// Word FIFO between the record controller and the record memory.
`timescale 1ns/1ps
module store_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW = $clog2(DEPTH)
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic srst,
    // Filling side.
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side.
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
        logic in_ready;
        logic out_valid;
    } fifo_state_type;

    fifo_state_type s;
    fifo_state_type next_s;
    logic push;
    logic pop;

    // Ready and valid are registered so both sides see clean flop outputs.
    always_comb begin
        next_s = s;
        push = in_valid && s.in_ready;
        pop = s.out_valid && out_ready;
        if (push) begin
            next_s.mem[s.wr] = in_data;
            next_s.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
        end
        if (pop) begin
            next_s.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
        end
        next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
        next_s.in_ready = next_s.cnt != (AW+1)'(DEPTH);
        next_s.out_valid = next_s.cnt != '0;
    end

    // State register.
    always_ff @(posedge mclk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign in_ready = s.in_ready;
    assign out_valid = s.out_valid;
    assign out_data = s.mem[s.rd];
endmodule : store_fifo

// ==== design/record_control.sv ====
// Disturbance record controller: history, triggers, lock-out, record slots.
`timescale 1ns/1ps
module record_control #(
    parameter int MS_CYCLES = recorder_pkg::MS_NS / recorder_pkg::CLK_NS
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic srst,
    // Settings.
    input wire logic enable,
    input wire logic [recorder_pkg::LEN_W-1:0] record_len,
    input wire logic [recorder_pkg::PCT_W-1:0] pretrig_pct,
    input wire logic [recorder_pkg::SPC_W-1:0] samples_per_cycle,
    input wire logic overwrite_mode,
    input wire logic [recorder_pkg::LOCK_W-1:0] lockout_ms,
    input wire logic [recorder_pkg::ANA_CH-1:0] style_ana,
    input wire logic [recorder_pkg::BIN_CH-1:0] style_bin,
    input wire logic style_man,
    input wire logic style_per,
    input wire logic [recorder_pkg::BIN_CH-1:0] bin_enable,
    // Signal sources.
    input wire logic sample_valid,
    input wire recorder_pkg::sample_type sample,
    output logic sample_ready,
    input wire logic cycle_tick,
    input wire logic [recorder_pkg::ANA_CH-1:0][recorder_pkg::SMP_W-1:0] trend_value,
    input wire logic [recorder_pkg::ANA_CH-1:0] ana_trig,
    input wire logic [recorder_pkg::BIN_CH-1:0] bin_trig,
    input wire logic manual_trig,
    input wire logic periodic_trig,
    // Host deletion.
    input wire logic clear_all,
    input wire logic del_cfg,
    input wire logic del_dat,
    input wire logic [recorder_pkg::SLOT_W-1:0] del_slot,
    // Host status.
    output logic [recorder_pkg::LOCK_CH-1:0][recorder_pkg::LOCK_W-1:0] lockout_remaining_object,
    output logic [recorder_pkg::SLOT_W:0] stored_count,
    output logic store_full_flag,
    output logic oldest_replaced_flag,
    output logic manual_fired_flag,
    output logic periodic_fired_flag,
    output logic status_event,
    output logic recording_active,
    output logic [recorder_pkg::SRC_W-1:0] last_source,
    // Record memory.
    output logic rec_start,
    output logic rec_trend,
    output logic [recorder_pkg::SLOT_W-1:0] rec_slot,
    output logic [recorder_pkg::CNT_W-1:0] rec_pre_len,
    output logic mem_valid,
    output recorder_pkg::store_word_type mem_word,
    input wire logic mem_ready
);
    localparam int MS_W = $clog2(MS_CYCLES + 1);
    localparam int PW = recorder_pkg::CNT_W + recorder_pkg::PCT_W;

    typedef struct packed {
        recorder_pkg::state_type st;
        logic [recorder_pkg::CNT_W-1:0] hist;
        logic [recorder_pkg::CNT_W-1:0] post;
        logic trend;
        logic [recorder_pkg::SRC_W-1:0] last_src;
        logic [recorder_pkg::LOCK_CH-1:0][recorder_pkg::LOCK_W-1:0] lock;
        logic [MS_W-1:0] ms;
        logic [recorder_pkg::MAX_REC-1:0] occ;
        logic [recorder_pkg::MAX_REC-1:0] cfg_gone;
        logic [recorder_pkg::MAX_REC-1:0] dat_gone;
        logic [recorder_pkg::SLOT_W-1:0] oldest;
        logic [recorder_pkg::SLOT_W-1:0] slot;
        logic [recorder_pkg::PCT_W-1:0] pct;
        logic [recorder_pkg::SLOT_W:0] count;
        logic full;
        logic replaced;
        logic man;
        logic per;
        logic event_p;
        logic active;
        logic start;
        logic [recorder_pkg::CNT_W-1:0] pre_len;
    } ctl_type;

    ctl_type s;
    ctl_type next_s;
    logic fifo_rdy;
    logic push;
    recorder_pkg::store_word_type word;
    logic [recorder_pkg::SRC_N-1:0] hits;
    logic [recorder_pkg::SRC_N-1:0] styles;
    logic [recorder_pkg::SRC_N-1:0] elig;
    logic [recorder_pkg::SRC_W-1:0] sel;
    logic any;
    logic accept;
    logic mem_full;
    logic [recorder_pkg::CNT_W-1:0] total;
    logic [PW-1:0] prod;
    logic [recorder_pkg::CNT_W-1:0] pre_target;
    logic [recorder_pkg::SLOT_W-1:0] free_slot;
    logic [recorder_pkg::SLOT_W:0] pop_cnt;
    logic ms_tick;
    logic flush;

    // ------------------------------------------------------------
    // Trigger qualification and record length arithmetic
    // ------------------------------------------------------------

    // Lowest-numbered eligible source wins when several fire together.
    always_comb begin
        hits = {periodic_trig, manual_trig, bin_trig & bin_enable, ana_trig};
        styles = {style_per, style_man, style_bin, style_ana};
        sel = '0;
        any = 1'b0;
        for (int i = 0; i < recorder_pkg::SRC_N; i++) begin
            elig[i] = hits[i];
            if (i < recorder_pkg::LOCK_CH) begin
                // Only channel sources are ever suppressed.
                if (lockout_ms != '0 && s.last_src == recorder_pkg::SRC_W'(i)
                        && s.lock[i % recorder_pkg::LOCK_CH] != '0) begin
                    elig[i] = 1'b0;
                end
            end
        end
        for (int i = recorder_pkg::SRC_N - 1; i >= 0; i--) begin
            if (elig[i]) begin
                sel = recorder_pkg::SRC_W'(i);
                any = 1'b1;
            end
        end
        mem_full = s.count == (recorder_pkg::SLOT_W+1)'(recorder_pkg::MAX_REC);
        // Busy and saturated states block triggering.
        accept = enable && any && s.st == recorder_pkg::ST_FILL && !flush
            && !(mem_full && !overwrite_mode);
    end

    // The divide by a constant rounds the history share down to a whole sample.
    always_comb begin
        total = recorder_pkg::CNT_W'(record_len) * recorder_pkg::CNT_W'(samples_per_cycle);
        prod = PW'(total) * PW'(pretrig_pct);
        pre_target = recorder_pkg::CNT_W'(prod / PW'(recorder_pkg::PCT_FULL));
        free_slot = '0;
        for (int i = recorder_pkg::MAX_REC - 1; i >= 0; i--) begin
            if (!s.occ[i]) begin
                free_slot = recorder_pkg::SLOT_W'(i);
            end
        end
    end

    // A pre-trigger percentage change, disable or delete-all restarts history from nothing.
    assign flush = clear_all || !enable || pretrig_pct != s.pct;
    assign ms_tick = s.ms == '0;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------

    // One process steps every field of the controller state.
    always_comb begin
        next_s = s;
        next_s.start = 1'b0;
        next_s.event_p = 1'b0;
        next_s.pct = pretrig_pct;
        push = 1'b0;
        word = '0;
        word.slot = s.slot;
        word.data = sample;
        word.data.binary = sample.binary & bin_enable;
        pop_cnt = '0;

        // Millisecond base and per-channel lock-out counters.
        next_s.ms = ms_tick ? MS_W'(MS_CYCLES - 1) : s.ms - 1'b1;
        for (int i = 0; i < recorder_pkg::LOCK_CH; i++) begin
            if (lockout_ms == '0) begin
                next_s.lock[i] = '0;
            end else if (ms_tick && s.lock[i] != '0) begin
                next_s.lock[i] = s.lock[i] - 1'b1;
            end
        end

        // A slot frees only when both of its files are gone.
        if (del_slot < recorder_pkg::SLOT_W'(recorder_pkg::MAX_REC)) begin
            if (del_cfg && s.occ[del_slot]) begin
                next_s.cfg_gone[del_slot] = 1'b1;
            end
            if (del_dat && s.occ[del_slot]) begin
                next_s.dat_gone[del_slot] = 1'b1;
            end
        end
        for (int i = 0; i < recorder_pkg::MAX_REC; i++) begin
            if (next_s.cfg_gone[i] && next_s.dat_gone[i]) begin
                next_s.occ[i] = 1'b0;
                next_s.cfg_gone[i] = 1'b0;
                next_s.dat_gone[i] = 1'b0;
            end
        end

        case (s.st)
            recorder_pkg::ST_FILL: begin
                // History runs constantly; the count saturates at the target.
                if (sample_valid && fifo_rdy && enable) begin
                    push = 1'b1;
                    word.kind = recorder_pkg::KIND_HIST;
                    if (s.hist < pre_target) begin
                        next_s.hist = s.hist + 1'b1;
                    end
                end
                if (accept) begin
                    next_s.st = recorder_pkg::ST_POST;
                    next_s.active = 1'b1;
                    next_s.start = 1'b1;
                    next_s.last_src = sel;
                    next_s.trend = styles[sel];
                    if (styles[sel]) begin
                        next_s.pre_len = '0;
                        next_s.post = recorder_pkg::CNT_W'(record_len)
                            * recorder_pkg::CNT_W'(recorder_pkg::TREND_MULT);
                    end else begin
                        // Missing history simply shortens the record.
                        next_s.pre_len = (s.hist < pre_target) ? s.hist : pre_target;
                        next_s.post = total - pre_target;
                    end
                    if (sel < recorder_pkg::SRC_W'(recorder_pkg::LOCK_CH)
                            && lockout_ms != '0) begin
                        next_s.lock[sel] = lockout_ms;
                    end
                    if (sel == recorder_pkg::SRC_W'(recorder_pkg::SRC_MAN)) begin
                        next_s.man = !s.man;
                        next_s.event_p = 1'b1;
                    end
                    if (sel == recorder_pkg::SRC_W'(recorder_pkg::SRC_PER)) begin
                        next_s.per = !s.per;
                        next_s.event_p = 1'b1;
                    end
                    if (mem_full) begin
                        // Oldest record gives way to the new one.
                        next_s.slot = s.oldest;
                        next_s.oldest = (s.oldest == recorder_pkg::SLOT_W'(recorder_pkg::MAX_REC - 1))
                            ? '0 : s.oldest + 1'b1;
                        next_s.replaced = !s.replaced;
                        next_s.event_p = 1'b1;
                    end else begin
                        next_s.slot = free_slot;
                    end
                    next_s.occ[next_s.slot] = 1'b1;
                    next_s.cfg_gone[next_s.slot] = 1'b0;
                    next_s.dat_gone[next_s.slot] = 1'b0;
                end
            end
            recorder_pkg::ST_POST: begin
                if (s.post == '0) begin
                    // The last word of the record is queued in the FIFO, so the active output drops.
                    next_s.st = recorder_pkg::ST_FILL;
                    next_s.active = 1'b0;
                    next_s.hist = '0;
                end else if (s.trend) begin
                    // A cycle strobe met by a full FIFO loses that entry.
                    if (cycle_tick && fifo_rdy) begin
                        push = 1'b1;
                        word.kind = recorder_pkg::KIND_TREND;
                        word.data.analog = trend_value;
                        next_s.post = s.post - 1'b1;
                    end
                end else if (sample_valid && fifo_rdy) begin
                    push = 1'b1;
                    word.kind = recorder_pkg::KIND_POST;
                    next_s.post = s.post - 1'b1;
                end
            end
            default: begin
                next_s.st = recorder_pkg::ST_FILL;
            end
        endcase

        // Flush overrides the state, history and post counts and active output set by the state step.
        if (flush) begin
            next_s.st = recorder_pkg::ST_FILL;
            next_s.hist = '0;
            next_s.post = '0;
            next_s.active = 1'b0;
        end
        if (clear_all) begin
            next_s.occ = '0;
            next_s.cfg_gone = '0;
            next_s.dat_gone = '0;
            next_s.oldest = '0;
        end

        for (int i = 0; i < recorder_pkg::MAX_REC; i++) begin
            pop_cnt = pop_cnt + (recorder_pkg::SLOT_W+1)'(next_s.occ[i]);
        end
        next_s.count = pop_cnt;
        // Full flag follows the count in both directions, and stays low in overwrite mode.
        next_s.full = !overwrite_mode
            && pop_cnt == (recorder_pkg::SLOT_W+1)'(recorder_pkg::MAX_REC);
        if (next_s.full != s.full) begin
            next_s.event_p = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge mclk) begin
        if (srst) begin
            s <= '0;
            s.st <= recorder_pkg::ST_FILL;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Record memory FIFO and outputs
    // ------------------------------------------------------------

    // Back-pressure reaches the source through sample_ready.
    store_fifo #(
        .WIDTH($bits(recorder_pkg::store_word_type)),
        .DEPTH(recorder_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .srst(srst),
        .in_valid(push),
        .in_data(word),
        .in_ready(fifo_rdy),
        .out_valid(mem_valid),
        .out_data(mem_word),
        .out_ready(mem_ready)
    );

    assign sample_ready = fifo_rdy;
    assign lockout_remaining_object = s.lock;
    assign stored_count = s.count;
    assign store_full_flag = s.full;
    assign oldest_replaced_flag = s.replaced;
    assign manual_fired_flag = s.man;
    assign periodic_fired_flag = s.per;
    assign status_event = s.event_p;
    assign recording_active = s.active;
    assign last_source = s.last_src;
    assign rec_start = s.start;
    assign rec_trend = s.trend;
    assign rec_slot = s.slot;
    assign rec_pre_len = s.pre_len;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    start_active_a: assert property (rec_start |-> recording_active)
        else $error("record start without active output");
    busy_reject_a: assert property (s.st == recorder_pkg::ST_POST |=> !rec_start)
        else $error("trigger accepted while recording");
    repeat_block_a: assert property (accept && sel < recorder_pkg::SRC_W'(recorder_pkg::LOCK_CH)
            && lockout_ms != '0 |-> !(sel == s.last_src && s.lock[sel] != '0))
        else $error("repeat trigger not suppressed");
    manual_free_a: assert property (manual_trig && hits[recorder_pkg::SRC_MAN-1:0] == '0
            && enable && !flush && s.st == recorder_pkg::ST_FILL
            && (!mem_full || overwrite_mode) |=> rec_start && manual_fired_flag != $past(manual_fired_flag))
        else $error("manual trigger lost");
    sat_stop_a: assert property (accept && !overwrite_mode |-> !mem_full)
        else $error("saturated memory accepted a trigger");
    replace_toggle_a: assert property (accept && mem_full |=>
            oldest_replaced_flag != $past(oldest_replaced_flag))
        else $error("replacement did not toggle flag");
    trend_nopre_a: assert property (rec_start && rec_trend |-> rec_pre_len == '0)
        else $error("trend record carries history");
    pct_flush_a: assert property (pretrig_pct != s.pct |=> !recording_active ##1 s.hist <= 1)
        else $error("percentage change did not flush");
    clear_all_a: assert property (clear_all |=> stored_count == '0 && !recording_active)
        else $error("delete-all left records");
    half_delete_a: assert property (del_cfg && !del_dat && !clear_all && !accept
            && del_slot == s.slot && s.occ[s.slot] && !s.dat_gone[s.slot] |=> s.occ[s.slot])
        else $error("slot freed by one file delete");
    zero_lock_a: assert property (lockout_ms == '0 |=> lockout_remaining_object == '0)
        else $error("lock-out counter runs at zero time");

    wave_rec_c: cover property (rec_start && !rec_trend ##[1:200] !recording_active);
    trend_rec_c: cover property (rec_start && rec_trend);
    replace_c: cover property (accept && mem_full);
    lock_c: cover property (s.st == recorder_pkg::ST_FILL && enable && any == 1'b0 && hits != '0);
endmodule : record_control

// ==== tb/record_store.sv ====
// Record memory model that stalls often so the store FIFO fills and refuses.
`timescale 1ns/1ps
module record_store (
    // Clock.
    input wire logic mclk,
    // Word stream from the controller.
    input wire logic mem_valid,
    input wire recorder_pkg::store_word_type mem_word,
    output logic mem_ready
);
    int trend_words = 0;
    // Drains slower than samples arrive, so back-pressure is exercised.
    always @(negedge mclk) mem_ready <= ($urandom % 8) < 3;
    // Counts the trend entries that the memory has taken, for the length check.
    always @(posedge mclk) begin
        if (mem_valid && mem_ready && mem_word.kind == recorder_pkg::KIND_TREND) begin
            trend_words <= trend_words + 1;
        end
    end
endmodule : record_store

// ==== tb/tb.sv ====
// Self-checking bench for the record controller and its memory model.
`timescale 1ns/1ps
module tb;
    logic mclk = 0, srst = 1, enable = 1, ovw = 0, sv = 0, tick = 0, took = 0;
    logic [13:0] trg = 0, sty = 14'h2000;
    logic [7:0] bin_en = 8'hff, stored_count;
    logic [2:0] op = 0;
    logic [19:0] lock = 0;
    logic [3:0] last_source;
    logic [4:0] exp_s;
    logic full, repl, f, act, rst_p, rtr, sready, mv, mr, pf, mf, ev_p;
    logic [6:0] pct = 7'h32;
    logic [11:0][19:0] lrem;
    logic [15:0] pre;
    recorder_pkg::sample_type smp = '0;
    recorder_pkg::store_word_type mw;
    logic [4:0] expq[$];
    int fail_count = 0, num_checks = 0, cyc = 0, ev = 0;
    // Free-running 40 MHz clock.
    initial forever #12.5 mclk = ~mclk;
    record_control #(.MS_CYCLES(4)) u_record_control (.mclk(mclk), .srst(srst),
        .enable(enable), .record_len(9'h001), .pretrig_pct(pct),
        .samples_per_cycle(6'h08), .overwrite_mode(ovw), .lockout_ms(lock),
        .style_ana(sty[3:0]), .style_bin(sty[11:4]), .style_man(sty[12]),
        .style_per(sty[13]), .bin_enable(bin_en), .sample_valid(sv), .sample(smp),
        .sample_ready(sready), .cycle_tick(tick), .trend_value(smp.analog),
        .ana_trig(trg[3:0]), .bin_trig(trg[11:4]), .manual_trig(trg[12]),
        .periodic_trig(trg[13]), .clear_all(op[2]), .del_cfg(op[0]), .del_dat(op[1]),
        .del_slot(7'h00), .lockout_remaining_object(lrem), .stored_count(stored_count),
        .store_full_flag(full), .oldest_replaced_flag(repl), .manual_fired_flag(mf),
        .periodic_fired_flag(pf), .status_event(ev_p), .recording_active(act),
        .last_source(last_source), .rec_start(rst_p), .rec_trend(rtr), .rec_slot(),
        .rec_pre_len(pre), .mem_valid(mv), .mem_word(mw), .mem_ready(mr));
    record_store u_record_store (.mclk(mclk), .mem_valid(mv), .mem_word(mw), .mem_ready(mr));
    task automatic chk(input bit ok, input string m);
        num_checks++;
        if (!ok) begin
            fail_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    // Pulses one source; an expected start is queued only when it must be taken.
    task automatic trig(input int s, input bit ok);
        if (ok) expq.push_back({s[3:0], sty[s]});
        @(negedge mclk) trg[s] = 1'b1;
        @(negedge mclk) trg[s] = 1'b0;
        repeat (3) @(negedge mclk);
        for (int n = 0; n < 3000 && act; n++) @(negedge mclk);
    endtask : trig
    task automatic host(input logic [2:0] o);
        @(negedge mclk) op = o;
        @(negedge mclk) op = 3'h0;
        @(negedge mclk);
    endtask : host
    // Samples are held until taken; the tick marks each fundamental cycle.
    always @(posedge mclk) took <= sv && sready;
    always @(negedge mclk) begin
        tick <= (cyc % 4) == 0;
        if (!sv || took) begin
            sv <= ($urandom % 4) != 0;
            smp <= {$urandom, $urandom, $urandom};
        end
    end
    // Each accepted record is compared with the oldest queued expectation.
    always @(posedge mclk) if (!srst && rst_p === 1'b1) begin
        exp_s = expq.size() ? expq.pop_front() : 5'h1f;
        chk({last_source, rtr} === exp_s, "wrong start");
        if (rtr === 1'b1) chk(pre === 16'h0, "trend history");
        else chk(pre <= 16'(8 * pct / 100), "history too long");
    end
    // Status event pulses are counted for the closing tally.
    always @(posedge mclk) if (!srst && ev_p === 1'b1) ev <= ev + 1;
    // A hang is cut short well past the expected run length.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fail_count++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(32'h4f16));
        repeat (12) @(negedge mclk);
        srst = 0;
        chk(stored_count === 8'h00 && act === 1'b0, "reset");
        lock = 20'h40;
        trig(0, 1);
        trig(0, 0);
        chk(lrem[0] !== 20'h0, "lock count");
        trig(13, 1);
        chk(pf === 1'b1, "periodic flag");
        trig(13, 1);
        lock = 20'h0;
        trig(4, 1);
        trig(4, 1);
        bin_en[7] = 1'b0;
        trig(11, 0);
        // A percentage change mid-record abandons that record at once.
        expq.push_back({4'hc, 1'b0});
        @(negedge mclk) trg[12] = 1'b1;
        @(negedge mclk) trg[12] = 1'b0;
        chk(act === 1'b1, "no manual start");
        @(negedge mclk) pct = 7'h19;
        @(negedge mclk) chk(act === 1'b0, "no flush");
        host(3'h4);
        for (int i = 0; i < 100; i++) trig(12, 1);
        chk(full === 1'b1 && stored_count === 8'h64, "not full");
        trig(12, 0);
        host(3'h1);
        chk(stored_count === 8'h64, "half delete");
        host(3'h2);
        chk(stored_count === 8'h63 && full === 1'b0, "full kept");
        trig(12, 1);
        ovw = 1'b1;
        f = repl;
        trig(12, 1);
        chk(repl !== f && stored_count === 8'h64, "no replace");
        host(3'h4);
        chk(stored_count === 8'h00 && act === 1'b0, "clear");
        chk(u_record_store.trend_words == 64, "trend length");
        chk(ev == 107 && mf === 1'b1, "event count");
        chk(expq.size() == 0, "start missing");
        give_verdict();
    end
endmodule : tb
